// ### rtl/cspt_pkg.sv
// constants and types shared by the companion serial target port
package cspt_pkg;

   // memory geometry, larger variant by default
   localparam int MEM_BYTES = 32768;
   localparam int MEM_AW = 15;
   localparam int ADDR_BYTES = 2;

   // companion special function registers
   localparam int SFR_COUNT = 30;
   localparam int SFR_AW = 5;

   // buffering of companion write events toward the core
   localparam int EVT_FIFO_DEPTH = 8;

   // fastest serial clock the port is meant for, in hertz
   localparam int SCK_MAX_HZ = 16000000;

   // standard serial memory op-codes
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WREN = 8'h06;

   // companion op-codes, disjoint from the memory set
   localparam logic [7:0] OP_CWRITE = 8'h12;
   localparam logic [7:0] OP_CREAD = 8'h13;

   // memory status byte layout
   localparam int ST_WEL = 1;
   localparam logic [7:0] ST_WR_MASK = 8'h8c;
   localparam logic [7:0] ST_RESET = 8'h00;

   // phase of the current selection
   typedef enum logic [3:0] {
      PH_OPC,
      PH_ADDR,
      PH_MWR,
      PH_MRD,
      PH_CWR,
      PH_CRD,
      PH_SRD,
      PH_SWR,
      PH_IDLE
   } cspt_phase_t;

   // one companion register write, as seen by the core
   typedef struct packed {
      logic [SFR_AW-1:0] addr;
      logic [7:0] data;
   } cspt_cevt_t;

   // per-selection state, rising serial clock edge
   typedef struct packed {
      cspt_phase_t phase;
      logic [7:0] opc;
      logic [2:0] bit_cnt;
      logic [1:0] abyte;
      logic [6:0] shift;
      logic [15:0] addr;
      logic [7:0] tx;
   } cspt_frame_t;

   // output stage, falling serial clock edge
   typedef struct packed {
      logic so;
      logic oe;
   } cspt_out_t;

endpackage : cspt_pkg

// ### rtl/cspt_target_port.sv
// companion serial target port: spi decode, memory, registers, event fifo
// Function
// - With chip select high the port is idle, ignores clock and input, and its output is not driven.
// - Input bits are taken on rising serial clock edges and output bits change on falling edges.
// - The port is fully static up to the top clock rate and keeps its state while the clock pauses.
// - The serial input is looked at only on rising serial clock edges.
// - The serial output is driven only while read data is returned.
// - Clock idle low and clock idle high selections are both accepted with the same edges.
// - Each op-code goes either to the memory or to the companion, never both.
// - The memory answers the standard serial memory op-code set.
// - Companion op-codes reach a bank of thirty special function registers.
// - Memory read and write commands always carry a two-byte address.
// - The memory is byte addressed and holds thirty-two thousand seven hundred sixty-eight bytes by default.
// - A memory write completes on the last clock of its byte with no busy time.
// - While the supervisor lockout is active all serial activity is ignored.
// - A companion write already taken is finished by the core even if lockout starts.
`timescale 1ns/100ps
`default_nettype none

module cspt_async_fifo #(
   parameter int W = 13,
   parameter int DEPTH = 8
) (
   input wire logic i_wr_clk,
   input wire logic i_wr_rst,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [W-1:0] i_wr_data,
   input wire logic i_rd_clk,
   input wire logic i_rd_rst,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [W-1:0] o_rd_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] sync1;
      logic [AW:0] sync2;
   } cspt_fptr_t;

   cspt_fptr_t wr_reg, wr_next, rd_reg, rd_next;
   logic [W-1:0] store [DEPTH];
   logic push;
   logic pop;

   // write side: full compares own gray against the synced read pointer
   always_comb begin
      wr_next = wr_reg;
      o_wr_ready = (wr_reg.gray != {~wr_reg.sync2[AW:AW-1], wr_reg.sync2[AW-2:0]});
      push = i_wr_valid && o_wr_ready;
      wr_next.sync1 = rd_reg.gray;
      wr_next.sync2 = wr_reg.sync1;
      if (push) begin
         wr_next.bin = wr_reg.bin + 1'b1;
         wr_next.gray = wr_next.bin ^ (wr_next.bin >> 1);
      end
   end

   always_ff @(posedge i_wr_clk or posedge i_wr_rst) begin
      if (i_wr_rst) begin
         wr_reg <= '0;
      end else begin
         wr_reg <= wr_next;
      end
   end

   // storage written only by the filling side
   always_ff @(posedge i_wr_clk) begin
      if (push) begin
         store[wr_reg.bin[AW-1:0]] <= i_wr_data;
      end
   end

   // read side: empty when own gray meets the synced write pointer
   always_comb begin
      rd_next = rd_reg;
      o_rd_valid = (rd_reg.gray != rd_reg.sync2);
      pop = o_rd_valid && i_rd_ready;
      rd_next.sync1 = wr_reg.gray;
      rd_next.sync2 = rd_reg.sync1;
      if (pop) begin
         rd_next.bin = rd_reg.bin + 1'b1;
         rd_next.gray = rd_next.bin ^ (rd_next.bin >> 1);
      end
   end

   assign o_rd_data = store[rd_reg.bin[AW-1:0]];

   always_ff @(posedge i_rd_clk or posedge i_rd_rst) begin
      if (i_rd_rst) begin
         rd_reg <= '0;
      end else begin
         rd_reg <= rd_next;
      end
   end

endmodule : cspt_async_fifo

module cspt_target_port
   import cspt_pkg::*;
#(
   parameter int MEM_SIZE = MEM_BYTES,
   parameter int FIFO_DEPTH = EVT_FIFO_DEPTH
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_sup_lock,
   output logic o_so,
   output logic o_so_oe,
   output logic o_cmp_valid,
   input wire logic i_cmp_ready,
   output cspt_cevt_t o_cmp_evt,
   output logic o_wel
);
   cspt_frame_t fr_reg, fr_next;
   cspt_out_t out_reg, out_next;
   logic [7:0] status_reg, status_next;
   logic [7:0] mem [MEM_SIZE];
   logic [7:0] sfr [SFR_COUNT];
   logic [1:0] wel_sync_reg;
   logic spi_rst;
   logic [7:0] byte_in;
   logic byte_done;
   logic mem_we;
   logic sfr_we;
   logic evt_valid;
   logic evt_ready;
   logic [15:0] addr_full;
   cspt_cevt_t evt_data;

   // companion register read with unmapped addresses as zero
   function automatic logic [7:0] sfr_read(input logic [15:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a < 16'(SFR_COUNT)) begin
         v = sfr[a[SFR_AW-1:0]];
      end
      return v;
   endfunction : sfr_read

   // selection, lockout or reset clear the frame asynchronously, since
   // the serial clock may never tick again after chip select rises
   assign spi_rst = i_cs_n || i_sup_lock || i_rst;

   assign byte_in = {fr_reg.shift, i_si};
   assign byte_done = (fr_reg.bit_cnt == 3'h7);
   assign addr_full = {fr_reg.addr[7:0], byte_in};

   // frame decoder, evaluated only at rising serial clock edges
   always_comb begin
      fr_next = fr_reg;
      mem_we = 1'b0;
      sfr_we = 1'b0;
      evt_valid = 1'b0;
      fr_next.shift = byte_in[6:0];
      fr_next.bit_cnt = fr_reg.bit_cnt + 3'h1;
      if (byte_done) begin
         case (fr_reg.phase)
            PH_OPC: begin
               // only the first byte of a selection is an op-code
               fr_next.opc = byte_in;
               fr_next.abyte = 2'h0;
               case (byte_in)
                  OP_READ: fr_next.phase = PH_ADDR;
                  OP_WRITE: fr_next.phase = status_reg[ST_WEL] ? PH_ADDR : PH_IDLE;
                  OP_CREAD: fr_next.phase = PH_ADDR;
                  OP_CWRITE: fr_next.phase = PH_ADDR;
                  OP_RDSR: begin
                     fr_next.phase = PH_SRD;
                     fr_next.tx = status_reg;
                  end
                  OP_WRSR: fr_next.phase = status_reg[ST_WEL] ? PH_SWR : PH_IDLE;
                  default: fr_next.phase = PH_IDLE;
               endcase
            end
            PH_ADDR: begin
               fr_next.abyte = fr_reg.abyte + 2'h1;
               fr_next.addr = addr_full;
               if (fr_reg.opc == OP_CREAD || fr_reg.opc == OP_CWRITE) begin
                  // companion address is a single byte
                  fr_next.phase = (fr_reg.opc == OP_CREAD) ? PH_CRD : PH_CWR;
                  fr_next.addr = {8'h00, byte_in};
                  if (fr_reg.opc == OP_CREAD) begin
                     fr_next.tx = sfr_read({8'h00, byte_in});
                     fr_next.addr = {8'h00, byte_in} + 16'h1;
                  end
               end else if (fr_reg.abyte == 2'(ADDR_BYTES - 1)) begin
                  fr_next.phase = (fr_reg.opc == OP_READ) ? PH_MRD : PH_MWR;
                  if (fr_reg.opc == OP_READ) begin
                     fr_next.tx = mem[addr_full[MEM_AW-1:0]];
                     fr_next.addr = addr_full + 16'h1;
                  end
               end
            end
            PH_MWR: begin
               mem_we = 1'b1;
               fr_next.addr = fr_reg.addr + 16'h1;
            end
            PH_MRD: begin
               fr_next.tx = mem[fr_reg.addr[MEM_AW-1:0]];
               fr_next.addr = fr_reg.addr + 16'h1;
            end
            PH_CWR: begin
               // a full event queue refuses the byte rather than losing it
               evt_valid = (fr_reg.addr < 16'(SFR_COUNT));
               sfr_we = evt_valid && evt_ready;
               fr_next.addr = fr_reg.addr + 16'h1;
            end
            PH_CRD: begin
               fr_next.tx = sfr_read(fr_reg.addr);
               fr_next.addr = fr_reg.addr + 16'h1;
            end
            PH_SRD: fr_next.tx = status_reg;
            PH_SWR: fr_next.phase = PH_IDLE;
            default: fr_next.phase = PH_IDLE;
         endcase
      end
   end

   // edges only, no timers: any clock rate and any pause are fine
   always_ff @(posedge i_sck or posedge spi_rst) begin
      if (spi_rst) begin
         fr_reg <= '0;
      end else begin
         fr_reg <= fr_next;
      end
   end

   // status byte survives selections; only core reset clears it
   always_comb begin
      status_next = status_reg;
      if (byte_done && fr_reg.phase == PH_OPC) begin
         if (byte_in == OP_WREN) begin
            status_next[ST_WEL] = 1'b1;
         end else if (byte_in == OP_WRDI || byte_in == OP_WRITE) begin
            status_next[ST_WEL] = 1'b0;
         end
      end else if (byte_done && fr_reg.phase == PH_SWR) begin
         status_next = (status_reg & ~ST_WR_MASK) | (byte_in & ST_WR_MASK);
         status_next[ST_WEL] = 1'b0;
      end
   end

   always_ff @(posedge i_sck or posedge i_rst) begin
      if (i_rst) begin
         status_reg <= ST_RESET;
      end else if (!i_cs_n && !i_sup_lock) begin
         status_reg <= status_next;
      end
   end

   // memory array written on the byte's last rising edge
   always_ff @(posedge i_sck) begin
      if (mem_we && !spi_rst) begin
         mem[fr_reg.addr[MEM_AW-1:0]] <= byte_in;
      end
   end

   // companion register bank, shadowed toward the core by events
   always_ff @(posedge i_sck or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < SFR_COUNT; k++) begin
            sfr[k] <= 8'h00;
         end
      end else if (sfr_we && !spi_rst) begin
         sfr[fr_reg.addr[SFR_AW-1:0]] <= byte_in;
      end
   end

   // output stage moves on falling edges only
   always_comb begin
      out_next.so = fr_reg.tx[~fr_reg.bit_cnt];
      out_next.oe = (fr_reg.phase == PH_MRD) || (fr_reg.phase == PH_CRD) || (fr_reg.phase == PH_SRD);
   end

   always_ff @(negedge i_sck or posedge spi_rst) begin
      if (spi_rst) begin
         out_reg <= '0;
      end else begin
         out_reg <= out_next;
      end
   end

   assign o_so = out_reg.so;
   assign o_so_oe = out_reg.oe;

   // fifo write side only resets with the core, so taken events survive
   assign evt_data.addr = fr_reg.addr[SFR_AW-1:0];
   assign evt_data.data = byte_in;

   cspt_async_fifo #(
      .W($bits(cspt_cevt_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_evt_fifo (
      .i_wr_clk(i_sck),
      .i_wr_rst(i_rst),
      .i_wr_valid(evt_valid && !spi_rst),
      .o_wr_ready(evt_ready),
      .i_wr_data(evt_data),
      .i_rd_clk(i_core_clk),
      .i_rd_rst(i_rst),
      .o_rd_valid(o_cmp_valid),
      .i_rd_ready(i_cmp_ready),
      .o_rd_data(o_cmp_evt)
   );

   // write enable latch level carried into the core domain
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wel_sync_reg <= 2'b00;
      end else begin
         wel_sync_reg <= {wel_sync_reg[0], status_reg[ST_WEL]};
      end
   end

   assign o_wel = wel_sync_reg[1];
   // checks on the serial side and on the core event output
   AST_CS_HIGH_QUIET: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_cs_n || i_sup_lock) |-> (!o_so_oe && fr_reg.phase == PH_OPC))
      else $error("output driven or decoder busy while deselected");

   AST_LOCK_QUIET: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_sup_lock |-> (fr_reg.bit_cnt == 3'h0 && !o_so_oe))
      else $error("serial activity seen during lockout");

   AST_IDLE_AFTER_CS: assert property (@(posedge i_core_clk) disable iff (i_rst)
      $rose(i_cs_n) |=> (fr_reg.phase == PH_OPC && fr_reg.opc == 8'h00))
      else $error("decoder not idle after deselect");

   AST_BYTE_FRAME: assert property (@(posedge i_sck) disable iff (spi_rst)
      (fr_reg.bit_cnt == 3'h0) |-> ##7 (fr_reg.bit_cnt == 3'h7))
      else $error("byte framing is not eight clocks");

   AST_NO_DRIVE_ON_WRITE: assert property (@(posedge i_sck) disable iff (spi_rst)
      (fr_reg.phase == PH_MWR || fr_reg.phase == PH_CWR || fr_reg.phase == PH_ADDR) |-> !o_so_oe)
      else $error("output driven outside a read");

   AST_WRITE_LANDS: assert property (@(posedge i_sck) disable iff (spi_rst)
      mem_we |=> (mem[$past(fr_reg.addr[MEM_AW-1:0])] == $past(byte_in)))
      else $error("memory byte not stored at end of its byte");

   AST_ADDR_TWO_BYTES: assert property (@(posedge i_sck) disable iff (spi_rst)
      (byte_done && fr_reg.phase == PH_OPC && byte_in == OP_READ) |-> ##8 (fr_reg.phase == PH_ADDR) ##9
      (fr_reg.phase == PH_MRD))
      else $error("memory read did not take two address bytes");

   AST_ROUTE_DISJOINT: assert property (@(posedge i_sck) disable iff (spi_rst)
      (fr_reg.opc == OP_CWRITE || fr_reg.opc == OP_CREAD) |-> !mem_we)
      else $error("companion op-code touched memory");

   AST_EVT_HELD: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (o_cmp_valid && !i_cmp_ready) |=> (o_cmp_valid && $stable(o_cmp_evt)))
      else $error("taken companion write lost before the core took it");

   COV_MEM_WRITE: cover property (@(posedge i_sck) disable iff (spi_rst) mem_we);
   COV_MEM_READ: cover property (@(posedge i_sck) disable iff (spi_rst) fr_reg.phase == PH_MRD && byte_done);
   COV_CMP_WRITE: cover property (@(posedge i_sck) disable iff (spi_rst) sfr_we);
   COV_EVT_FULL: cover property (@(posedge i_sck) disable iff (spi_rst) evt_valid && !evt_ready);

endmodule : cspt_target_port

`default_nettype wire

// ### verif/cspt_host_model.sv
// behavioural host master driving the serial link of the target port
`timescale 1ns/100ps
`default_nettype none

module cspt_host_model (
   input wire logic i_so,
   input wire logic i_so_oe,
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   output logic o_rx_stb,
   output logic [7:0] o_rx_byte
);
   localparam time HALF = 32ns;

   // link idles deselected, clock stopped between frames
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b1;
      o_rx_stb = 1'b0;
      o_rx_byte = 8'h00;
   end

   // one selection; clock idles at the level of the chosen mode
   task sel(input logic m3, input int pause, input logic [7:0] tx[$]);
      logic [7:0] rx;
      logic rd;
      o_sck = m3;
      #(HALF);
      o_cs_n = 1'b0; // fresh selection for each call of the task
      #(HALF);
      foreach (tx[i]) begin
         rd = 1'b1;
         for (int b = 7; b >= 0; b--) begin
            o_sck = 1'b0;
            o_si = tx[i][b]; // msb first, eight clocks a byte
            #(HALF);
            o_sck = 1'b1; // both sides take bits on the rise
            rx[b] = i_so;
            rd = rd & (i_so_oe === 1'b1);
            #(HALF);
         end
         // only whole bytes returned under enable count as read data
         if (rd) begin
            o_rx_byte = rx;
            o_rx_stb = 1'b1;
            #1;
            o_rx_stb = 1'b0;
         end
         if (i == pause) #(40 * HALF); // slow host: clock stopped mid-frame
      end
      o_sck = m3;
      #(HALF);
      o_cs_n = 1'b1;
      o_si = ~o_si; // released line must not keep showing the last bit
      #(HALF);
   endtask : sel
endmodule : cspt_host_model

`default_nettype wire

// ### verif/companion_spi_target_port_bench.sv
// self-checking bench for the companion serial target port
`timescale 1ns/100ps
`default_nettype none

module companion_spi_target_port_bench import cspt_pkg::*;;
   logic clk, rst, sck, cs_n, si, lock, so, so_oe, cvalid, cready, wel, stb;
   logic [7:0] rxb;
   cspt_cevt_t evt;
   logic [7:0] exp_rd[$];
   cspt_cevt_t exp_ev[$];
   logic [7:0] q[$];
   logic [7:0] d[4];
   logic [15:0] a;
   logic [31:0] seed = 32'd53;
   logic hold_ready = 1'b1;
   logic cready_init = 1'b0;
   logic cs_prev = 1'b1;
   int errors = 0;
   int comparisons = 0;
   int k;
   localparam int FIFO_DEPTH_CHK = EVT_FIFO_DEPTH;

   cspt_target_port dut_u (.i_core_clk(clk), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
      .i_sup_lock(lock), .o_so(so), .o_so_oe(so_oe), .o_cmp_valid(cvalid), .i_cmp_ready(cready),
      .o_cmp_evt(evt), .o_wel(wel));
   cspt_host_model host_u (.i_so(so), .i_so_oe(so_oe), .o_sck(sck), .o_cs_n(cs_n), .o_si(si),
      .o_rx_stb(stb), .o_rx_byte(rxb));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task finish_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   // the latch crosses into the core domain in two or three clocks
   task wel_chk(input logic e);
      repeat (5) @(posedge clk);
      chk("wel", {15'h0, e}, {15'h0, wel});
   endtask : wel_chk

   // read bytes seen by the host against the oldest note
   always @(posedge stb) begin
      if (exp_rd.size() == 0) chk("unexpected read", 16'h0100, {8'h00, rxb});
      else chk("read byte", {8'h00, exp_rd.pop_front()}, {8'h00, rxb});
   end

   // events popped at the core side, and the output quiet while deselected
   always @(posedge clk) begin
      if (cvalid === 1'b1 && cready === 1'b1) begin
         if (exp_ev.size() == 0) chk("unexpected event", 16'hffff, {3'b000, evt});
         else chk("event", {3'b000, exp_ev.pop_front()}, {3'b000, evt});
      end
      // deselect seen one clock earlier too, so the async clear has surely landed
      if (cs_prev === 1'b1 && cs_n === 1'b1 && so_oe !== 1'b0) chk("idle so_oe", 16'h0, {15'h0, so_oe});
      cs_prev = cs_n;
   end

   // random pops just after the edge, unless a test holds them off
   always @(posedge clk) begin
      if (cready_init == 1'b0) begin
         cready = 1'b0;
         cready_init = 1'b1;
      end
      #1;
      cready = ~hold_ready & (xs() > 32'h7fffffff);
   end

   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      $display("mismatch timeout expected done seen hang");
      finish_test();
   end

   initial begin
      rst = 1'b1;
      lock = 1'b0;
      repeat (4) @(posedge clk);
      chk("valid in reset", 16'h0, {15'h0, cvalid});
      #1 rst = 1'b0;
      hold_ready = 1'b0;
      #3.3;
      host_u.sel(1'b0, -1, '{OP_WREN});
      wel_chk(1'b1);
      exp_rd = '{8'h02, 8'h02};
      host_u.sel(1'b1, -1, '{OP_RDSR, 8'h00, 8'h00});
      host_u.sel(1'b0, -1, '{OP_WRITE, 8'h00, 8'h10, 8'ha5, 8'h5a});
      wel_chk(1'b0);
      host_u.sel(1'b0, -1, '{OP_WRITE, 8'h00, 8'h10, 8'hff}); // refused without the latch
      host_u.sel(1'b0, -1, '{OP_WREN, OP_WRITE, 8'h00, 8'h10, 8'h77});
      wel_chk(1'b1);
      host_u.sel(1'b0, -1, '{OP_WRITE, 8'hff, 8'hff, 8'h11, 8'h22});
      host_u.sel(1'b0, -1, '{8'h0a, OP_READ, 8'h00, 8'h10, 8'h00});
      exp_rd = '{8'ha5, 8'h5a, 8'h11, 8'h22};
      host_u.sel(1'b1, 3, '{OP_READ, 8'h00, 8'h10, 8'h00, 8'h00});
      host_u.sel(1'b0, -1, '{OP_READ, 8'h7f, 8'hff, 8'h00, 8'h00});
      // status write keeps only the writable bits and drops the latch
      host_u.sel(1'b0, -1, '{OP_WREN});
      host_u.sel(1'b1, -1, '{OP_WRSR, 8'hff});
      exp_rd = '{ST_WR_MASK};
      host_u.sel(1'b0, -1, '{OP_RDSR, 8'h00});
      host_u.sel(1'b0, -1, '{OP_WREN});
      host_u.sel(1'b0, -1, '{OP_WRDI});
      wel_chk(1'b0);
      $display("memory tests done");
      for (int r = 0; r < 3; r++) begin
         a = 16'(xs() & 32'h7fff);
         q = '{OP_WRITE, a[15:8], a[7:0]};
         foreach (d[i]) begin
            d[i] = 8'(xs());
            q.push_back(d[i]);
            exp_rd.push_back(d[i]);
         end
         host_u.sel(1'b0, -1, '{OP_WREN});
         host_u.sel(r[0], -1, q);
         host_u.sel(~r[0], -1, '{OP_READ, a[15:8], a[7:0], 8'h00, 8'h00, 8'h00, 8'h00});
      end
      $display("random tests done");
      @(posedge clk);
      #1 lock = 1'b1;
      host_u.sel(1'b0, -1, '{OP_WREN});
      host_u.sel(1'b0, -1, '{OP_CWRITE, 8'h05, 8'h99});
      @(posedge clk);
      #1 lock = 1'b0;
      wel_chk(1'b0);
      $display("lockout test done");
      exp_ev.push_back(cspt_cevt_t'{addr: 5'h1d, data: 8'hd1});
      exp_ev.push_back(cspt_cevt_t'{addr: 5'h10, data: 8'h3c});
      host_u.sel(1'b0, -1, '{OP_CWRITE, 8'h1d, 8'hd1, 8'he2});
      host_u.sel(1'b1, -1, '{OP_CWRITE, 8'h10, 8'h3c});
      exp_rd = '{8'hd1, 8'h00, 8'h00, 8'ha5};
      host_u.sel(1'b0, -1, '{OP_CREAD, 8'h1d, 8'h00, 8'h00});
      host_u.sel(1'b0, -1, '{OP_CREAD, 8'h05, 8'h00});
      host_u.sel(1'b0, -1, '{OP_READ, 8'h00, 8'h10, 8'h00});
      $display("companion tests done");
      hold_ready = 1'b1;
      repeat (3) @(posedge clk);
      q = '{OP_CWRITE, 8'h00};
      for (int i = 0; i < 10; i++) begin
         q.push_back(8'h40 + i[7:0]);
         if (i < FIFO_DEPTH_CHK) exp_ev.push_back(cspt_cevt_t'{addr: i[4:0], data: 8'h40 + i[7:0]});
      end
      host_u.sel(1'b0, -1, q);
      exp_rd = '{8'h00, 8'h00};
      host_u.sel(1'b0, -1, '{OP_CREAD, 8'h08, 8'h00, 8'h00});
      hold_ready = 1'b0;
      for (k = 0; k < 400 && (exp_ev.size() > 0 || cvalid === 1'b1); k++) @(posedge clk);
      if (k == 400) begin
         errors++;
         $display("mismatch drain expected empty seen busy");
      end
      chk("pending reads", 16'h0, 16'(exp_rd.size()));
      $display("fifo test done");
      finish_test();
   end

endmodule : companion_spi_target_port_bench

`default_nettype wire
